/* File: src/fsk_rx_preamble_sync_detect.v */
// fsk receive acquisition: preamble detector and sync word detector
// with an 8-bit register port for its configuration and status.
// assumes demodulator bits and correlator values come from logic on
// sys_clk, each qualified by a one-cycle valid pulse.
//
// Notes on behaviour
// - searching preamble: listen, freeze status zero
// - correlation above threshold: lock, freeze one
// - timeout on: leave lock after preamble length
// - timeout off: leave lock when correlation drops
// - sync search only while preamble locked
// - dual sense: two hypotheses tested together
// - dual sense decision table, word zero preferred
// - single sense: word zero then one, decision zero
// - winning interpretation picks raw and fec
// - strict quality: only fully matching words accepted
// - each sync word sixteen bits, two bytes
// - interpretation bit zero selects raw mode
// - interpretation top bit enables fec
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "fsk_sync_defines.vh"
`default_nettype none

module fsk_rx_preamble_sync_detect #(
  parameter CORR_W = 8                  // correlator value width
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              sys_rst,
  // receive control
  input  wire              rx_enable,         // high while in receive
  input  wire              frame_done,        // later stages finished frame
  // demodulator stream
  input  wire              bit_valid,         // one estimate per pulse
  input  wire              bit_value,         // binary frequency estimate
  input  wire              corr_valid,        // correlator sample strobe
  input  wire [CORR_W-1:0] corr_value,        // processed correlator output
  // register port
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  // detector results
  output wire              gain_freeze_status, // high while locked or synced
  output reg               sync_found,         // one-cycle pulse on detection
  output reg               sync_decision_flag, // winning word index
  output reg               raw_mode_enable,    // raw decoding for this frame
  output reg               fec_enable          // fec decoding for this frame
);

  // ************************************
  // helpers
  // ************************************
  // number of equal bits between received window and a sync word
  function [4:0] match_count;
    input [15:0] rx;
    input [15:0] word;
    integer      i;
    reg   [4:0]  n;
    begin
      n = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        n = n + {4'h0, ~(rx[i] ^ word[i])};
      end
      match_count = n;
    end
  endfunction

  // hypothesis test: above threshold, and full match when strict
  function hypo;
    input [4:0] cnt;
    input [3:0] thr;
    input       strict;
    begin
      hypo = (cnt > {1'b0, thr}) && (!strict || cnt == `FULL_MATCH);
    end
  endfunction

  // ************************************
  // configuration registers
  // ************************************
  reg [7:0]  ctrl;          // timeout, detect mode, single sense, strict
  reg [7:0]  pre_thr;       // preamble_detect_threshold
  reg [3:0]  sync_thr;      // sync_threshold
  reg [3:0]  interp;        // word one [3:2], word zero [1:0]
  reg [7:0]  plen_high;     // preamble_length_high
  reg [7:0]  plen_low;      // preamble_length_low
  reg [7:0]  sw0_high;      // sync_word_zero_high
  reg [7:0]  sw0_low;       // sync_word_zero_low
  reg [7:0]  sw1_high;      // sync_word_one_high
  reg [7:0]  sw1_low;       // sync_word_one_low

  wire        preamble_timeout_enable = ctrl[`CTRL_TIMEOUT];
  wire        preamble_detect_mode    = ctrl[`CTRL_PDMODE];
  wire        single_sense_select     = ctrl[`CTRL_SINGLE];
  wire        sync_strict_quality     = ctrl[`CTRL_STRICT];
  wire [1:0]  word_zero_interpretation = interp[1:0];
  wire [1:0]  word_one_interpretation  = interp[3:2];
  wire [15:0] sync_word_zero = {sw0_high, sw0_low};
  wire [15:0] sync_word_one  = {sw1_high, sw1_low};

  // register writes; host keeps the radio off while changing these
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl      <= `RST_CTRL;
      pre_thr   <= `RST_PRE_THR;
      sync_thr  <= `RST_SYNC_THR;
      interp    <= `RST_INTERP;
      plen_high <= `RST_PLEN_HIGH;
      plen_low  <= `RST_PLEN_LOW;
      sw0_high  <= `RST_WORD;
      sw0_low   <= `RST_WORD;
      sw1_high  <= `RST_WORD;
      sw1_low   <= `RST_WORD;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CTRL:      ctrl      <= {4'h0, reg_wdata[3:0]};
        `OFS_PRE_THR:   pre_thr   <= reg_wdata;
        `OFS_SYNC_THR:  sync_thr  <= reg_wdata[3:0];
        `OFS_INTERP:    interp    <= reg_wdata[3:0];
        `OFS_PLEN_HIGH: plen_high <= reg_wdata;
        `OFS_PLEN_LOW:  plen_low  <= reg_wdata;
        `OFS_SW0_HIGH:  sw0_high  <= reg_wdata;
        `OFS_SW0_LOW:   sw0_low   <= reg_wdata;
        `OFS_SW1_HIGH:  sw1_high  <= reg_wdata;
        `OFS_SW1_LOW:   sw1_low   <= reg_wdata;
        default:        ctrl      <= ctrl;  // unmapped or read-only: ignored
      endcase
    end
  end

  // ************************************
  // detector state
  // ************************************
  reg  [1:0]  state;        // listen, lock or sync
  reg  [1:0]  next_state;
  reg  [31:0] shift;        // last received estimates, newest in bit 0
  reg  [5:0]  fill;         // estimates collected since lock, saturating
  reg  [18:0] lock_bits;    // estimates spent in lock, for the timeout
  reg         above_prev;   // previous correlator sample above threshold

  wire [31:0] next_shift = {shift[30:0], bit_value};
  wire [5:0]  need_bits  = single_sense_select ? `CONCAT_BITS : `WORD_BITS;
  wire        window_ok  = ({1'b0, fill} + 7'h01) >= {1'b0, need_bits};
  wire [18:0] limit_bits = {plen_high, plen_low, 3'h0};  // octets to bits
  wire        corr_above = corr_value > pre_thr[CORR_W-1:0];

  // both words tested on the same window
  wire h0 = hypo(match_count(next_shift[15:0], sync_word_zero), sync_thr,
                 sync_strict_quality);
  wire h1 = hypo(match_count(next_shift[15:0], sync_word_one), sync_thr,
                 sync_strict_quality);
  // word zero first, then word one directly after it
  // strict mode demands every bit to agree
  wire hs = hypo(match_count(next_shift[31:16], sync_word_zero), sync_thr,
                 sync_strict_quality) &&
            hypo(match_count(next_shift[15:0], sync_word_one), sync_thr,
                 sync_strict_quality);

  // sync search only on fresh bits while locked
  wire        try_sync = (state == `ST_LOCK) && bit_valid && window_ok;
  wire        hit      = try_sync && (single_sense_select ? hs : (h0 || h1));
  // word zero wins when both hold; single sense always zero
  wire        win_one  = !single_sense_select && !h0 && h1;
  wire [1:0]  win_cfg  = win_one ? word_one_interpretation
                                 : word_zero_interpretation;

  // lock entry; mode one wants two samples in a row above threshold
  wire        lock_in  = corr_valid && corr_above &&
                         (!preamble_detect_mode || above_prev);
  // timeout once the preamble length has passed without sync
  wire        time_out = preamble_timeout_enable && bit_valid &&
                         (lock_bits + 19'h00001) >= limit_bits;
  // without timeout, lock ends as correlation falls
  wire        corr_lost = !preamble_timeout_enable && corr_valid && !corr_above;

  // next-state decision
  always @* begin
    next_state = state;
    case (state)
      `ST_LISTEN: begin
        // stay listening until a preamble shows
        if (lock_in) begin
          next_state = `ST_LOCK;
        end
      end
      `ST_LOCK: begin
        // a found word takes priority over a lock loss in the same cycle
        if (hit) begin
          next_state = `ST_SYNC;
        end else if (time_out || corr_lost) begin
          next_state = `ST_LISTEN;
        end
      end
      `ST_SYNC: begin
        // held for later decoding stages until the frame ends
        if (frame_done) begin
          next_state = `ST_LISTEN;
        end
      end
      default: begin
        next_state = `ST_LISTEN;
      end
    endcase
    if (!rx_enable) begin
      next_state = `ST_LISTEN;
    end
  end

  // state, bit window and counters
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // reset starts in search with nothing pending
      state      <= `ST_LISTEN;
      shift      <= 32'h00000000;
      fill       <= 6'h00;
      lock_bits  <= 19'h00000;
      above_prev <= 1'b0;
    end else begin
      state <= next_state;
      // correlator history for the two-sample detect mode
      if (!rx_enable) begin
        above_prev <= 1'b0;
      end else if (corr_valid) begin
        above_prev <= corr_above;
      end
      if (next_state != `ST_LOCK || state != `ST_LOCK) begin
        // fresh window and timeout on every lock entry
        shift     <= 32'h00000000;
        fill      <= 6'h00;
        lock_bits <= 19'h00000;
      end else if (bit_valid) begin
        shift     <= next_shift;
        lock_bits <= lock_bits + 19'h00001;
        if (fill != `CONCAT_BITS) begin
          fill <= fill + 6'h01;
        end
      end
    end
  end

  // freeze status follows the detector state
  assign gain_freeze_status = (state != `ST_LISTEN);

  // ************************************
  // sync decision outputs
  // ************************************
  // decision latched when the word is found, cleared back in listen
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_found         <= 1'b0;
      sync_decision_flag <= 1'b0;
      raw_mode_enable    <= 1'b0;
      fec_enable         <= 1'b0;
    end else begin
      sync_found <= hit && rx_enable;
      if (hit && rx_enable) begin
        sync_decision_flag <= win_one;
        raw_mode_enable    <= win_cfg[`INTERP_RAW];
        fec_enable         <= win_cfg[`INTERP_FEC];
      end else if (next_state == `ST_LISTEN) begin
        // no decision pending once back in search
        sync_decision_flag <= 1'b0;
        raw_mode_enable    <= 1'b0;
        fec_enable         <= 1'b0;
      end
    end
  end

  // ************************************
  // register read port
  // ************************************
  // data stand in the cycle after the strobe only; zero otherwise
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_CTRL:      reg_rdata <= ctrl;
        `OFS_PRE_THR:   reg_rdata <= pre_thr;
        `OFS_SYNC_THR:  reg_rdata <= {4'h0, sync_thr};
        `OFS_INTERP:    reg_rdata <= {4'h0, interp};
        `OFS_PLEN_HIGH: reg_rdata <= plen_high;
        `OFS_PLEN_LOW:  reg_rdata <= plen_low;
        `OFS_SW0_HIGH:  reg_rdata <= sw0_high;
        `OFS_SW0_LOW:   reg_rdata <= sw0_low;
        `OFS_SW1_HIGH:  reg_rdata <= sw1_high;
        `OFS_SW1_LOW:   reg_rdata <= sw1_low;
        `OFS_STATUS:    reg_rdata <= {3'h0, fec_enable, raw_mode_enable,
                                      sync_decision_flag, state == `ST_SYNC,
                                      gain_freeze_status};
        default:        reg_rdata <= 8'h00;  // unmapped reads as zero
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: src/fsk_sync_defines.vh */
// constants of the fsk receive acquisition block: register offsets,
// field positions, reset values and state codes.
// assumes an 8-bit register port with byte offsets given below.
`ifndef FSK_SYNC_DEFINES_VH
`define FSK_SYNC_DEFINES_VH

// ************************************
// register offsets
// ************************************
`define OFS_CTRL        8'h00
`define OFS_PRE_THR     8'h01
`define OFS_SYNC_THR    8'h02
`define OFS_INTERP      8'h03
`define OFS_PLEN_HIGH   8'h04
`define OFS_PLEN_LOW    8'h05
`define OFS_SW0_HIGH    8'h06
`define OFS_SW0_LOW     8'h07
`define OFS_SW1_HIGH    8'h08
`define OFS_SW1_LOW     8'h09
`define OFS_STATUS      8'h0a

// ************************************
// field positions
// ************************************
`define CTRL_TIMEOUT    0
`define CTRL_PDMODE     1
`define CTRL_SINGLE     2
`define CTRL_STRICT     3
`define INTERP_RAW      0
`define INTERP_FEC      1
`define ST_FREEZE       0
`define ST_SYNCED       1
`define ST_DECISION     2
`define ST_RAW          3
`define ST_FEC          4

// ************************************
// reset values
// ************************************
`define RST_CTRL        8'h00
`define RST_PRE_THR     8'h40
`define RST_SYNC_THR    4'h8
`define RST_INTERP      4'h0
`define RST_PLEN_HIGH   8'h00
`define RST_PLEN_LOW    8'h08
`define RST_WORD        8'h00

// ************************************
// detector states and figures
// ************************************
`define ST_LISTEN       2'h0
`define ST_LOCK         2'h1
`define ST_SYNC         2'h2
`define WORD_BITS       6'h10
`define CONCAT_BITS     6'h20
`define FULL_MATCH      5'h10

`endif

/* File: verif/fsk_sync_checker.sv */
// checker for the acquisition block, bound to its top module
// assumes config copies below track the register port writes
`timescale 1ns/1ps
`include "fsk_sync_defines.vh"
`default_nettype none
module fsk_sync_checker #(
  parameter CORR_W = 8
) (
  // clock, reset and inputs
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              rx_enable,
  input wire logic              bit_valid,
  input wire logic              corr_valid,
  input wire logic [CORR_W-1:0] corr_value,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  // outputs watched
  input wire logic [7:0]        reg_rdata,
  input wire logic              gain_freeze_status,
  input wire logic              sync_found,
  input wire logic              sync_decision_flag,
  input wire logic              raw_mode_enable,
  input wire logic              fec_enable
);
  logic [7:0] thr;     // preamble threshold copy
  logic [3:0] ctrl;    // control copy
  logic [3:0] interp;  // interpretation copy
  logic       in_sync; // synced, not yet back in listen
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ************************************
  // copies of config, sync tracking
  // ************************************
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thr <= `RST_PRE_THR;
      ctrl <= 4'h0;
      interp <= `RST_INTERP;
      in_sync <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `OFS_PRE_THR) thr <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_CTRL) ctrl <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `OFS_INTERP) interp <= reg_wdata[3:0];
      in_sync <= sync_found | (in_sync & gain_freeze_status);
    end
  end
  // ************************************
  // assertions
  // ************************************
  AST_RESET: assert property (disable iff (1'b0) sys_rst |=> !gain_freeze_status && !sync_found)
    else $error("outputs not cleared in reset");
  AST_LISTEN: assert property (!rx_enable |=> !gain_freeze_status && !sync_decision_flag
    && !raw_mode_enable && !fec_enable) else $error("receive off did not return to search");
  AST_LOCK: assert property ($rose(gain_freeze_status) |-> $past(corr_valid)
    && $past(corr_value) > $past(thr)) else $error("lock without correlation above threshold");
  AST_DROP: assert property (gain_freeze_status && !in_sync && !sync_found && corr_valid
    && !bit_valid && corr_value <= thr && !ctrl[0] && rx_enable |=> !gain_freeze_status)
    else $error("lock kept after correlation drop");
  AST_SYNC_IN_LOCK: assert property (sync_found |-> $past(bit_valid) && $past(gain_freeze_status))
    else $error("sync outside lock");
  AST_SINGLE: assert property (sync_found && ctrl[2] |-> !sync_decision_flag)
    else $error("single sense decision not zero");
  AST_INTERP: assert property (sync_found |-> raw_mode_enable == interp[{sync_decision_flag, 1'b0}]
    && fec_enable == interp[{sync_decision_flag, 1'b1}]) else $error("wrong interpretation");
  AST_PULSE: assert property (sync_found |=> !sync_found)
    else $error("sync pulse too long");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RD_STATUS: assert property (reg_rd && reg_addr == `OFS_STATUS |=>
    reg_rdata[0] == $past(gain_freeze_status)) else $error("status freeze bit wrong");
endmodule
`default_nettype wire

/* File: verif/fsk_sender_model.sv */
// remote sender model: correlator samples of a preamble, then a word
// assumes start is a one-cycle pulse, never raised while busy
`timescale 1ns/1ps
`default_nettype none
module fsk_sender_model (
  // clock and command
  input  wire logic        sys_clk,
  input  wire logic        start,
  input  wire logic [3:0]  pre_cnt, // correlator samples
  input  wire logic [7:0]  pre_val, // value of each sample
  input  wire logic [5:0]  nbits,   // word bits, msb first
  input  wire logic [31:0] word,
  input  wire logic [1:0]  gap,     // idle cycles between bits
  output var  logic        busy,
  // demodulator side
  output var  logic        bit_valid,
  output var  logic        bit_value,
  output var  logic        corr_valid,
  output var  logic [7:0]  corr_value
);
  // one command at a time; stale lines are inverted, except bit_value after the last bit when gap is zero
  initial begin
    {busy, bit_valid, bit_value, corr_valid, corr_value} = 12'h000;
    forever begin
      @(posedge sys_clk);
      if (start) begin
        busy <= 1'b1;
        repeat (pre_cnt) begin
          corr_valid <= 1'b1;
          corr_value <= pre_val;
          @(posedge sys_clk);
        end
        corr_valid <= 1'b0;
        corr_value <= ~pre_val;
        for (int i = nbits - 1; i >= 0; i--) begin
          bit_valid <= 1'b1;
          bit_value <= word[i];
          @(posedge sys_clk);
          if (gap != 2'h0) begin
            bit_valid <= 1'b0;
            bit_value <= ~word[i];
            repeat (gap) @(posedge sys_clk);
          end
        end
        bit_valid <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/fsk_rx_preamble_sync_detect_tb.sv */
// bench of the acquisition block: register tasks plus sender model
// assumes the model owns the demodulator inputs, the bench the rest
`timescale 1ns/1ps
`include "fsk_sync_defines.vh"
`default_nettype none
module fsk_rx_preamble_sync_detect_tb;
  logic        sys_clk = 0, sys_rst = 1, rx_enable = 0, frame_done = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pre_val = 8'h00, corr_value;
  logic        reg_wr = 0, reg_rd = 0, start = 0, busy, bit_valid, bit_value, corr_valid;
  logic        gain_freeze_status, sync_found, sync_decision_flag, raw_mode_enable, fec_enable;
  logic [3:0]  pre_cnt = 4'h0, seen = 4'h0, h0;  // sync pulses seen, and before send
  logic [5:0]  nbits = 6'h00;
  logic [31:0] word = 32'h0;
  logic [1:0]  gap = 2'h0;
  int          bad_count = 0, total_checks = 0, cycles = 0;
  fsk_rx_preamble_sync_detect #(.CORR_W(8)) fsk_rx_preamble_sync_detect_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .rx_enable(rx_enable), .frame_done(frame_done), .bit_valid(bit_valid),
    .bit_value(bit_value), .corr_valid(corr_valid), .corr_value(corr_value), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gain_freeze_status(gain_freeze_status), .sync_found(sync_found),
    .sync_decision_flag(sync_decision_flag), .raw_mode_enable(raw_mode_enable),
    .fec_enable(fec_enable));
  fsk_sender_model fsk_sender_model_i (.sys_clk(sys_clk), .start(start), .pre_cnt(pre_cnt),
    .pre_val(pre_val), .nbits(nbits), .word(word), .gap(gap), .busy(busy),
    .bit_valid(bit_valid), .bit_value(bit_value), .corr_valid(corr_valid),
    .corr_value(corr_value));
  // ************************************
  // clock, pulse count, hang guard
  // ************************************
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (sync_found === 1'b1) seen <= seen + 4'h1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      $display("MISMATCH %0t run did not finish in time", $time);
      give_verdict();
    end
  end
  // ************************************
  // tasks
  // ************************************
  task give_verdict;
    if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one sender command, waits until the sender is no longer busy, then two cycles more
  task send(input logic [3:0] n, input logic [7:0] v, input logic [5:0] b, input logic [31:0] w);
    int t;
    h0 = seen;
    @(posedge sys_clk);
    {start, pre_cnt, pre_val, nbits, word} <= {1'b1, n, v, b, w};
    @(posedge sys_clk);
    start <= 1'b0;
    t = 0;
    #1 while (busy && t < 500) begin
      @(posedge sys_clk);
      #1 t++;
    end
    // a sender that never finishes counts as a failure
    if (busy) begin
      bad_count++;
      $display("MISMATCH %0t sender did not finish", $time);
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task outc(input logic [3:0] e);
    chk({4'h0, seen != h0, sync_decision_flag, raw_mode_enable, fec_enable}, {4'h0, e});
  endtask
  task fz(input logic e);
    chk({7'h0, gain_freeze_status}, {7'h0, e});
  endtask
  task drop;
    @(posedge sys_clk);
    rx_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({4'h0, gain_freeze_status, sync_decision_flag, raw_mode_enable, fec_enable}, 8'h00);
    @(posedge sys_clk);
    rx_enable <= 1'b1;
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`OFS_PRE_THR, `RST_PRE_THR);
    rd(`OFS_SYNC_THR, {4'h0, `RST_SYNC_THR});
    rd(`OFS_PLEN_LOW, `RST_PLEN_LOW);
    rd(8'h0b, 8'h00);
    wr(`OFS_SW0_HIGH, 8'h90);
    wr(`OFS_SW0_LOW, 8'h4e);
    wr(`OFS_SW1_HIGH, 8'h7a);
    wr(`OFS_SW1_LOW, 8'h0d);
    wr(`OFS_INTERP, 8'h09);
    // frontend matched to the sample rate by the host
    rx_enable <= 1'b1;
    send(4'h0, 8'h00, 6'd16, 32'h904e);
    outc(4'h0);
    send(4'h1, 8'h40, 6'd0, 32'h0);
    fz(1'b0);
    send(4'h1, 8'h41, 6'd16, 32'h7a0d);
    outc(4'hd);
    rd(`OFS_STATUS, 8'h17);
    @(posedge sys_clk);
    frame_done <= 1'b1;
    @(posedge sys_clk);
    frame_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 fz(1'b0);
    send(4'h1, 8'h41, 6'd16, 32'h904e);
    outc(4'ha);
    drop();
    wr(`OFS_SW1_HIGH, 8'h90);
    wr(`OFS_SW1_LOW, 8'h4e);
    send(4'h1, 8'h41, 6'd16, 32'h904e);
    outc(4'ha);
    drop();
    wr(`OFS_SW1_HIGH, 8'h7a);
    wr(`OFS_SW1_LOW, 8'h0d);
    send(4'h1, 8'h41, 6'd0, 32'h0);
    send(4'h1, 8'h40, 6'd0, 32'h0);
    fz(1'b0);
    wr(`OFS_CTRL, 8'h01);
    wr(`OFS_PLEN_LOW, 8'h01);
    send(4'h1, 8'h41, 6'd7, 32'h7f);
    fz(1'b1);
    send(4'h0, 8'h00, 6'd1, 32'h0);
    fz(1'b0);
    drop();
    wr(`OFS_CTRL, 8'h02);
    send(4'h1, 8'h41, 6'd0, 32'h0);
    fz(1'b0);
    send(4'h2, 8'h41, 6'd0, 32'h0);
    fz(1'b1);
    drop();
    wr(`OFS_CTRL, 8'h04);
    gap <= 2'h1;
    send(4'h1, 8'h41, 6'd16, 32'h7a0d);
    outc(4'h0);
    send(4'h0, 8'h00, 6'd32, 32'h904e7a0d);
    outc(4'ha);
    drop();
    gap <= 2'h0;
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_SYNC_THR, 8'h0e);
    send(4'h1, 8'h41, 6'd16, 32'h904f);
    outc(4'ha);
    drop();
    wr(`OFS_CTRL, 8'h08);
    send(4'h1, 8'h41, 6'd16, 32'h904f);
    outc(4'h0);
    send(4'h0, 8'h00, 6'd16, 32'h904e);
    outc(4'ha);
    drop();
    give_verdict();
  end
endmodule
bind fsk_rx_preamble_sync_detect fsk_sync_checker #(.CORR_W(CORR_W)) chk_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .rx_enable(rx_enable), .bit_valid(bit_valid), .corr_valid(corr_valid),
  .corr_value(corr_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_freeze_status(gain_freeze_status),
  .sync_found(sync_found), .sync_decision_flag(sync_decision_flag),
  .raw_mode_enable(raw_mode_enable), .fec_enable(fec_enable));
`default_nettype wire
